/* File: ealm_delay.sv */
`timescale 1ns/10ps
module ealm_delay #(
    parameter int DELAY_MS = ealm_pkg::DEF_DELAY_MS
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ms_tick_in,
    input wire logic raw_in,
    output logic filt_out
);
    import ealm_pkg::*;

    logic [MS_W-1:0] count;

    if (DELAY_MS < 1 || DELAY_MS >= (1 << MS_W))
    begin : g_bad_delay
        $error("delay out of counter range");
    end

    // Follows raw_in only after it differs for DELAY_MS ticks
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            count <= 12'h000;
            filt_out <= 1'h0;
        end
        else if (raw_in == filt_out)
        begin
            count <= 12'h000;
        end
        else if (ms_tick_in)
        begin
            if (count == MS_W'(DELAY_MS - 1)) // see R23
            begin
                filt_out <= raw_in;
                count <= 12'h000;
            end
            else
            begin
                count <= count + 12'h001;
            end
        end
    end

    chk_delay_on_tick: assert property ( // see R23
        @(posedge clock_in) disable iff (!rstn_in)
        $changed(filt_out) |-> $past(ms_tick_in) && $past(raw_in) == filt_out)
        else $error("filter output moved off a tick");
endmodule

/* File: ealm_far_end.sv */
`timescale 1ns/10ps
module ealm_far_end (
    input wire logic [3:0] cond0_in,
    input wire logic [3:0] cond1_in,
    output logic [1:0] lof_out,
    output logic [1:0] ais_out,
    output logic [1:0] remote_alarm_bit_three_out,
    output logic [1:0] los_out,
    output logic [1:0] ber_out,
    output logic [1:0] crc_out,
    output logic [1:0] mfl_out,
    output logic [1:0] rmf_out,
    output logic [1:0] ts16_out
);
    // One fault code per span, 0 is a clean span
    assign lof_out = {cond1_in == 4'h1, cond0_in == 4'h1};
    assign ais_out = {cond1_in == 4'h2, cond0_in == 4'h2};
    assign remote_alarm_bit_three_out = {cond1_in == 4'h3, cond0_in == 4'h3};
    assign los_out = {cond1_in == 4'h4, cond0_in == 4'h4};
    assign ber_out = {cond1_in == 4'h5, cond0_in == 4'h5};
    assign crc_out = {cond1_in == 4'h6, cond0_in == 4'h6};
    assign mfl_out = {cond1_in == 4'h7, cond0_in == 4'h7};
    assign rmf_out = {cond1_in == 4'h8, cond0_in == 4'h8};
    assign ts16_out = {cond1_in == 4'h9, cond0_in == 4'h9};
endmodule

/* File: ealm_pkg.sv */
package ealm_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int URG_MIN_MS = 500;
    localparam int URG_MAX_MS = 750;
    localparam int URG_DELAY_MS = (URG_MIN_MS + URG_MAX_MS) / 2;
    localparam int DEF_MIN_MS = 250;
    localparam int DEF_MAX_MS = 500;
    localparam int DEF_DELAY_MS = (DEF_MIN_MS + DEF_MAX_MS) / 2;
    localparam int HOLD_LAMP_MS = 1000;
    localparam int HOLD_HIST_MS = 3000;
    localparam int LAMP_TEST_MS = 3000;
    localparam int FLASH_HALF_MS = 250;
    localparam int POWERUP_MS = 1000;
    localparam int MS_W = 12;
    localparam int NUM_SPANS = 2;
    localparam int SPAN_DROP = 0;
    localparam int SPAN_LINE = 1;
    localparam int HIST_W = 3;

    typedef enum logic [1:0] {
        BTN_IDLE = 2'b00,
        BTN_SHORT = 2'b01,
        BTN_LAMP = 2'b10,
        BTN_HIST = 2'b11
    } ealm_btn_t;

    typedef enum logic [2:0] {
        HIST_NONE = 3'b000,
        HIST_LOCAL = 3'b001,
        HIST_REMOTE = 3'b010,
        HIST_AIS = 3'b011,
        HIST_MF_LOCAL = 3'b100,
        HIST_MF_REMOTE = 3'b101,
        HIST_MF_AIS = 3'b110
    } ealm_hist_t;
endpackage

/* File: ealm_top.sv */
`timescale 1ns/10ps
// Behaviour
// R01 - Loopback copies send input to receive out
// R02 - Loopback copies receive input to send out
// R03 - Steady local lamp on signal, frame, error loss
// R04 - Steady remote lamp on upstream sync loss
// R05 - Steady AIS lamp on all-ones input
// R06 - Flash local and remote on multiframe loss
// R07 - Flash AIS lamp on timeslot 16 all-ones
// R08 - Urgent alarm on sync loss or fatal faults
// R09 - Urgent alarm asserted during power-up
// R10 - Deferred alarm on AIS, remote, minor faults
// R11 - Service relay follows urgent or deferred
// R12 - Cut-off press lights lamp, restores relays
// R13 - Hold over one second runs lamp test
// R14 - Hold over three seconds shows, clears history
// R15 - Cleared alarm identity stored per span
// R16 - Sync loss gives local lamp, sends AIS
// R17 - Urgent declared 500 to 750 ms after loss
// R18 - Urgent retired 500 to 750 ms after return
// R19 - Input AIS sent on, deferred after delay
// R20 - AIS end stops AIS, deferred retires later
// R21 - Remote bit passed on, deferred at once
// R22 - Remote bit clear retires deferred at once
// R23 - Timing from millisecond tick counters
module ealm_top #(
    parameter int MS_TICK_CYCLES = ealm_pkg::TICK_CYCLES
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic loopback_in,
    input wire logic send_in_data_in,
    input wire logic recv_in_data_in,
    input wire logic norm_send_out_data_in,
    input wire logic norm_recv_out_data_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] los_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] lof_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] crc_loss_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] ber_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] mf_loss_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] remote_alarm_bit_three_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] remote_mf_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] ais_in,
    input wire logic [ealm_pkg::NUM_SPANS-1:0] ais_ts16_in,
    input wire logic selftest_all_fail_in,
    input wire logic selftest_any_fail_in,
    input wire logic internal_fault_in,
    input wire logic supply_5v_lost_in,
    input wire logic converter_fail_in,
    input wire logic alarm_cutoff_in,
    output logic send_out_data_out,
    output logic recv_out_data_out,
    output logic [ealm_pkg::NUM_SPANS-1:0] tx_ais_out,
    output logic [ealm_pkg::NUM_SPANS-1:0] tx_remote_bit_out,
    output logic [ealm_pkg::NUM_SPANS-1:0] led_local_out,
    output logic [ealm_pkg::NUM_SPANS-1:0] led_remote_out,
    output logic [ealm_pkg::NUM_SPANS-1:0] led_ais_out,
    output logic led_alarm_cutoff_out,
    output logic alarm_history_display_out,
    output logic [ealm_pkg::NUM_SPANS*ealm_pkg::HIST_W-1:0] history_code_out,
    output logic urgent_relay_out,
    output logic deferred_relay_out,
    output logic service_relay_out
);
    import ealm_pkg::*;

    localparam int TW = $clog2(MS_TICK_CYCLES + 1);

    if (MS_TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("tick period too short");
    end

    function automatic ealm_hist_t hist_code(input logic [5:0] falls);
        ealm_hist_t code;
        code = HIST_NONE;
        if (falls[5])
            code = HIST_MF_AIS;
        else if (falls[4])
            code = HIST_MF_REMOTE;
        else if (falls[3])
            code = HIST_MF_LOCAL;
        else if (falls[2])
            code = HIST_AIS;
        else if (falls[1])
            code = HIST_REMOTE;
        else if (falls[0])
            code = HIST_LOCAL;
        return code;
    endfunction

    logic [TW-1:0] tick_cnt;
    logic ms_tick;
    logic [MS_W-1:0] flash_cnt;
    logic flash_phase;
    logic [MS_W-1:0] pwr_cnt;
    logic powerup_busy;
    logic btn_s1;
    logic btn_s2;
    logic btn_s3;
    logic btn_pressed;
    logic btn_prev;
    logic [MS_W-1:0] hold_ms;
    ealm_btn_t btn_state;
    ealm_btn_t next_btn_state;
    logic hist_clear;
    logic [MS_W-1:0] lamp_ms;
    logic lamp_on;
    logic [NUM_SPANS-1:0] local_now;
    logic [NUM_SPANS-1:0] sync_loss;
    logic [NUM_SPANS-1:0] ais_any;
    logic [NUM_SPANS-1:0] urg_filt;
    logic [NUM_SPANS-1:0] def_filt;
    logic [5:0] cond [NUM_SPANS];
    logic [5:0] cond_prev [NUM_SPANS];
    ealm_hist_t hist [NUM_SPANS];
    logic urgent_decl;
    logic deferred_decl;
    logic ack_urg;
    logic ack_def;
    logic [MS_W-1:0] urg_wait;

    // Millisecond tick
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            tick_cnt <= '0;
        else if (tick_cnt == TW'(MS_TICK_CYCLES - 1)) // see R23
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + TW'(1);
    end

    assign ms_tick = (tick_cnt == TW'(MS_TICK_CYCLES - 1));

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            flash_cnt <= 12'h000;
            flash_phase <= 1'h0;
        end
        else if (ms_tick)
        begin
            if (flash_cnt == MS_W'(FLASH_HALF_MS - 1))
            begin
                flash_cnt <= 12'h000;
                flash_phase <= ~flash_phase;
            end
            else
            begin
                flash_cnt <= flash_cnt + 12'h001;
            end
        end
    end

    // Power-up urgent hold
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pwr_cnt <= 12'h000;
            powerup_busy <= 1'h1;
        end
        else if (powerup_busy && ms_tick)
        begin
            pwr_cnt <= pwr_cnt + 12'h001;
            if (pwr_cnt == MS_W'(POWERUP_MS - 1)) // see R09
                powerup_busy <= 1'h0;
        end
    end

    // Per-span condition classification
    always_comb
    begin
        for (int s = 0; s < NUM_SPANS; s++)
        begin
            local_now[s] = los_in[s] | lof_in[s] | crc_loss_in[s] | ber_in[s];
            sync_loss[s] = local_now[s] | mf_loss_in[s]; // see R08
            ais_any[s] = ais_in[s] | ais_ts16_in[s]; // see R10
            cond[s] = {ais_ts16_in[s], remote_mf_in[s], mf_loss_in[s],
                ais_in[s], remote_alarm_bit_three_in[s], local_now[s]};
        end
    end

    for (genvar g = 0; g < NUM_SPANS; g++)
    begin : g_span
        ealm_delay #(.DELAY_MS(URG_DELAY_MS)) u_urg ( // see R17 see R18
            .clock_in(clock_in),
            .rstn_in(rstn_in),
            .ms_tick_in(ms_tick),
            .raw_in(sync_loss[g]),
            .filt_out(urg_filt[g])
        );
        ealm_delay #(.DELAY_MS(DEF_DELAY_MS)) u_def ( // see R19 see R20
            .clock_in(clock_in),
            .rstn_in(rstn_in),
            .ms_tick_in(ms_tick),
            .raw_in(ais_any[g]),
            .filt_out(def_filt[g])
        );
    end

    // Lamps, AIS and remote bit transmission
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            led_local_out <= '0;
            led_remote_out <= '0;
            led_ais_out <= '0;
            tx_ais_out <= '0;
            tx_remote_bit_out <= '0;
        end
        else
        begin
            led_local_out <= {NUM_SPANS{lamp_on}} | local_now // see R03 see R16
                | (mf_loss_in & {NUM_SPANS{flash_phase}}); // see R06
            led_remote_out <= {NUM_SPANS{lamp_on}}
                | remote_alarm_bit_three_in // see R04
                | (remote_mf_in & {NUM_SPANS{flash_phase}}); // see R06
            led_ais_out <= {NUM_SPANS{lamp_on}} | ais_in // see R05
                | (ais_ts16_in & {NUM_SPANS{flash_phase}}); // see R07
            tx_ais_out <= sync_loss | ais_any; // see R16 see R19 see R20
            tx_remote_bit_out <= remote_alarm_bit_three_in; // see R21
        end
    end

    // Output streams, loopback takes precedence
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            send_out_data_out <= 1'h1;
            recv_out_data_out <= 1'h1;
        end
        else
        begin
            if (loopback_in)
                send_out_data_out <= recv_in_data_in; // see R02
            else if (sync_loss[SPAN_DROP] | ais_any[SPAN_DROP])
                send_out_data_out <= 1'h1;
            else
                send_out_data_out <= norm_send_out_data_in;
            if (loopback_in)
                recv_out_data_out <= send_in_data_in; // see R01
            else if (sync_loss[SPAN_LINE] | ais_any[SPAN_LINE])
                recv_out_data_out <= 1'h1;
            else
                recv_out_data_out <= norm_recv_out_data_in;
        end
    end

    // System alarm declaration
    assign urgent_decl = powerup_busy | (|urg_filt) // see R08 see R09
        | selftest_all_fail_in | internal_fault_in | supply_5v_lost_in;
    assign deferred_decl = (|def_filt) | (|remote_alarm_bit_three_in) // see R10
        | (|remote_mf_in) | selftest_any_fail_in // see R21 see R22
        | converter_fail_in;

    // Cut-off button: three-stage sampling
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            btn_s1 <= 1'h0;
            btn_s2 <= 1'h0;
            btn_s3 <= 1'h0;
            btn_pressed <= 1'h0;
            btn_prev <= 1'h0;
        end
        else
        begin
            btn_s1 <= alarm_cutoff_in;
            btn_s2 <= btn_s1;
            btn_s3 <= btn_s2;
            if (btn_s2 == btn_s3)
                btn_pressed <= btn_s3;
            btn_prev <= btn_pressed;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            hold_ms <= 12'h000;
        else if (!btn_pressed)
            hold_ms <= 12'h000;
        else if (ms_tick && hold_ms != MS_W'(HOLD_HIST_MS))
            hold_ms <= hold_ms + 12'h001; // see R23
    end

    always_comb
    begin
        next_btn_state = btn_state;
        unique case (btn_state)
            BTN_IDLE:
                if (btn_pressed)
                    next_btn_state = BTN_SHORT;
            BTN_SHORT:
                if (!btn_pressed)
                    next_btn_state = BTN_IDLE;
                else if (hold_ms == MS_W'(HOLD_LAMP_MS)) // see R13
                    next_btn_state = BTN_LAMP;
            BTN_LAMP:
                if (!btn_pressed)
                    next_btn_state = BTN_IDLE;
                else if (hold_ms == MS_W'(HOLD_HIST_MS)) // see R14
                    next_btn_state = BTN_HIST;
            BTN_HIST:
                if (!btn_pressed)
                    next_btn_state = BTN_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            btn_state <= BTN_IDLE;
        else
            btn_state <= next_btn_state;
    end

    assign hist_clear = (btn_state == BTN_HIST) && !btn_pressed; // see R14
    assign alarm_history_display_out = (btn_state == BTN_HIST); // see R14

    // Lamp test timer
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            lamp_ms <= 12'h000;
        else if (btn_state == BTN_SHORT && next_btn_state == BTN_LAMP)
            lamp_ms <= MS_W'(LAMP_TEST_MS); // see R13
        else if (ms_tick && lamp_ms != 12'h000)
            lamp_ms <= lamp_ms - 12'h001;
    end

    assign lamp_on = (lamp_ms != 12'h000);

    // Alarm cut-off acknowledge, cleared when the alarm retires
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ack_urg <= 1'h0;
            ack_def <= 1'h0;
        end
        else
        begin
            if (!urgent_decl)
                ack_urg <= 1'h0;
            else if (btn_pressed && !btn_prev)
                ack_urg <= 1'h1; // see R12
            if (!deferred_decl)
                ack_def <= 1'h0;
            else if (btn_pressed && !btn_prev)
                ack_def <= 1'h1; // see R12
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            urgent_relay_out <= 1'h0;
            deferred_relay_out <= 1'h0;
            service_relay_out <= 1'h0;
            led_alarm_cutoff_out <= 1'h0;
        end
        else
        begin
            urgent_relay_out <= urgent_decl & ~ack_urg;
            deferred_relay_out <= deferred_decl & ~ack_def;
            service_relay_out <= (urgent_decl & ~ack_urg) // see R11
                | (deferred_decl & ~ack_def);
            led_alarm_cutoff_out <= ack_urg | ack_def | lamp_on; // see R12
        end
    end

    // Alarm history, a new clear wins over the history wipe
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            for (int s = 0; s < NUM_SPANS; s++)
            begin
                hist[s] <= HIST_NONE;
                cond_prev[s] <= 6'h00;
            end
        end
        else
        begin
            for (int s = 0; s < NUM_SPANS; s++)
            begin
                cond_prev[s] <= cond[s];
                if (|(cond_prev[s] & ~cond[s]))
                    hist[s] <= hist_code(cond_prev[s] & ~cond[s]); // see R15
                else if (hist_clear)
                    hist[s] <= HIST_NONE; // see R14
            end
        end
    end

    always_comb
    begin
        for (int s = 0; s < NUM_SPANS; s++)
            history_code_out[s*HIST_W +: HIST_W] = hist[s];
    end

    // Checking helper: ticks spent waiting for urgent on line span
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            urg_wait <= 12'h000;
        else if (!sync_loss[SPAN_LINE] || urg_filt[SPAN_LINE])
            urg_wait <= 12'h000;
        else if (ms_tick)
            urg_wait <= urg_wait + 12'h001;
    end

    chk_loop_drop_copy: assert property ( // see R01
        @(posedge clock_in) disable iff (!rstn_in)
        loopback_in |=> recv_out_data_out == $past(send_in_data_in))
        else $error("drop loopback bit mismatch");

    chk_loop_line_copy: assert property ( // see R02
        @(posedge clock_in) disable iff (!rstn_in)
        loopback_in |=> send_out_data_out == $past(recv_in_data_in))
        else $error("line loopback bit mismatch");

    chk_local_lamp_on: assert property ( // see R03
        @(posedge clock_in) disable iff (!rstn_in)
        (los_in[0] | ber_in[0]) |=> led_local_out[0])
        else $error("local lamp not lit");

    chk_remote_lamp_on: assert property ( // see R04
        @(posedge clock_in) disable iff (!rstn_in)
        remote_alarm_bit_three_in[1] |=> led_remote_out[1])
        else $error("remote lamp not lit");

    chk_ais_lamp_on: assert property ( // see R05
        @(posedge clock_in) disable iff (!rstn_in)
        ais_in[0] |=> led_ais_out[0])
        else $error("ais lamp not lit");

    chk_ais_sent_line: assert property ( // see R16
        @(posedge clock_in) disable iff (!rstn_in)
        (lof_in[1] && !loopback_in) |=> tx_ais_out[1] && recv_out_data_out)
        else $error("ais not sent on sync loss");

    chk_powerup_urgent: assert property ( // see R09
        @(posedge clock_in) disable iff (!rstn_in)
        (rstn_in && powerup_busy && !ack_urg) |=> urgent_relay_out)
        else $error("urgent missing at power-up");

    chk_service_follows: assert property ( // see R11
        @(posedge clock_in) disable iff (!rstn_in)
        service_relay_out == (urgent_relay_out | deferred_relay_out))
        else $error("service relay mismatch");

    chk_urgent_window: assert property ( // see R17
        @(posedge clock_in) disable iff (!rstn_in)
        $rose(urg_filt[SPAN_LINE]) |-> $past(urg_wait) >= 12'(URG_MIN_MS - 1)
            && $past(urg_wait) <= 12'(URG_MAX_MS))
        else $error("urgent outside its window");

    chk_bit_three_def: assert property ( // see R21
        @(posedge clock_in) disable iff (!rstn_in)
        (remote_alarm_bit_three_in[0] && !ack_def) |=> deferred_relay_out)
        else $error("deferred not immediate");

    chk_lamp_test_all: assert property ( // see R13
        @(posedge clock_in) disable iff (!rstn_in)
        lamp_on |=> &{led_local_out, led_remote_out, led_ais_out})
        else $error("lamp test left a lamp dark");

    cov_loopback: cover property (
        @(posedge clock_in) disable iff (!rstn_in) loopback_in[*4]);
    cov_lamp_test: cover property (
        @(posedge clock_in) disable iff (!rstn_in) $rose(lamp_on));
    cov_history_clear: cover property (
        @(posedge clock_in) disable iff (!rstn_in) hist_clear);
    cov_urgent_rise: cover property (
        @(posedge clock_in) disable iff (!rstn_in) $rose(urg_filt[1]));
endmodule

/* File: test_e1_alarm_loopback_manager.sv */
`timescale 1ns/10ps
module test_e1_alarm_loopback_manager;
    import ealm_pkg::*;
    localparam int T = 4;
    logic clock_in, rstn_in, loopback, send_in, recv_in, nsend, nrecv;
    logic alarm_cutoff;
    logic [3:0] cond0, cond1;
    logic [4:0] flt;
    logic [1:0] los, lof, crc, ber, mfl, rbit3, rmf, ais, ts16;
    logic send_out, recv_out, cut_led, hdisp, urgent, deferred, service;
    logic [1:0] tx_ais, tx_rb, led_l, led_r, led_a, rel;
    logic [5:0] hist, leds;
    logic [15:0] seed;
    logic [3:0] q[$];
    logic [5:0] tab [1:9];
    int error_cnt, check_count, n, on, off;

    ealm_far_end i_far (.cond0_in(cond0), .cond1_in(cond1),
        .lof_out(lof), .ais_out(ais), .remote_alarm_bit_three_out(rbit3),
        .ber_out(ber), .crc_out(crc), .mfl_out(mfl), .rmf_out(rmf),
        .los_out(los), .ts16_out(ts16));

    ealm_top #(.MS_TICK_CYCLES(T)) i_dut (
        .clock_in(clock_in), .rstn_in(rstn_in), .loopback_in(loopback),
        .send_in_data_in(send_in), .recv_in_data_in(recv_in),
        .norm_send_out_data_in(nsend), .norm_recv_out_data_in(nrecv),
        .los_in(los), .lof_in(lof), .crc_loss_in(crc), .ber_in(ber),
        .mf_loss_in(mfl), .remote_alarm_bit_three_in(rbit3),
        .remote_mf_in(rmf), .ais_in(ais), .ais_ts16_in(ts16),
        .selftest_all_fail_in(flt[0]), .internal_fault_in(flt[1]),
        .supply_5v_lost_in(flt[2]), .selftest_any_fail_in(flt[3]),
        .converter_fail_in(flt[4]), .alarm_cutoff_in(alarm_cutoff),
        .send_out_data_out(send_out), .recv_out_data_out(recv_out),
        .tx_ais_out(tx_ais), .tx_remote_bit_out(tx_rb),
        .led_local_out(led_l), .led_remote_out(led_r), .led_ais_out(led_a),
        .led_alarm_cutoff_out(cut_led), .alarm_history_display_out(hdisp),
        .history_code_out(hist), .urgent_relay_out(urgent),
        .deferred_relay_out(deferred), .service_relay_out(service));

    assign rel = {deferred, urgent};
    assign leds = {led_a, led_r, led_l};

    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic final_report;
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_win(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock_in);
    endtask

    task automatic settle;
        @(posedge clock_in);
        @(negedge clock_in);
    endtask

    // Bounded wait on a relay, counted in cycles
    task automatic wait_rel(input int idx, input logic lvl, input int lim);
        n = 0;
        while (rel[idx] !== lvl && n < lim)
        begin
            @(negedge clock_in);
            n++;
        end
        if (n >= lim)
        begin
            error_cnt++;
            final_report;
        end
    endtask

    task automatic set_cond(input int sp, input logic [3:0] c);
        @(posedge clock_in);
        if (sp == 1)
            cond1 <= c;
        else
            cond0 <= c;
    endtask

    task automatic stream(input logic lb);
        logic [3:0] v;
        q.delete();
        @(posedge clock_in);
        loopback <= lb;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clock_in);
            v = seed[3:0];
            seed = lfsr(seed);
            {nrecv, nsend, recv_in, send_in} <= v;
            q.push_back(v);
            @(negedge clock_in);
            if (i > 1)
            begin
                chk(recv_out, lb ? q[$-1][0] : q[$-1][3]);
                chk(send_out, lb ? q[$-1][1] : q[$-1][2]);
            end
        end
    endtask

    task automatic timed(input int sp, input logic [3:0] c, input int idx,
                         input int lo, input int hi);
        set_cond(sp, c);
        settle;
        chk(tx_ais[sp], 1'b1);
        chk(sp == 1 ? recv_out : send_out, 1'b1);
        wait_rel(idx, 1'b1, hi * T + 20);
        chk_win(n, lo * T - 2, hi * T + 8);
        chk(service, 1'b1);
        set_cond(sp, 4'h0);
        settle;
        chk(tx_ais[sp], 1'b0);
        wait_rel(idx, 1'b0, hi * T + 20);
        chk_win(n, lo * T - 2, hi * T + 8);
    endtask

    initial
    begin
        {rstn_in, loopback, send_in, recv_in, nsend, nrecv} = 6'h00;
        alarm_cutoff = 1'b0;
        flt = 5'h00;
        cond0 = 4'h0;
        cond1 = 4'h0;
        seed = 16'hA7E2;
        error_cnt = 0;
        check_count = 0;
        // Code: history, flashing, lamp kind
        tab = '{6'h08, 6'h1A, 6'h11, 6'h08, 6'h08, 6'h08, 6'h24, 6'h2D, 6'h36};
        repeat (5) @(posedge clock_in);
        rstn_in <= 1'b1;
        settle;
        chk(urgent, 1'b1);
        chk(service, 1'b1);
        stream(1'b1);
        stream(1'b0);
        cyc(1100 * T);
        settle;
        chk(rel, 2'b00);
        chk(service, 1'b0);
        // Module faults: first three urgent, last two deferred
        for (int f = 0; f < 5; f++)
        begin
            @(posedge clock_in);
            flt <= 5'h01 << f;
            settle;
            chk(rel, f < 3 ? 2'b01 : 2'b10);
            @(posedge clock_in);
            flt <= 5'h00;
        end
        timed(1, 4'h1, 0, 500, 750);
        timed(0, 4'h2, 1, 250, 500);
        set_cond(1, 4'h3);
        settle;
        chk(tx_rb[1], 1'b1);
        chk(led_r[1], 1'b1);
        wait_rel(1, 1'b1, 3);
        set_cond(1, 4'h0);
        wait_rel(1, 1'b0, 4);
        set_cond(1, 4'h3);
        wait_rel(1, 1'b1, 4);
        @(posedge clock_in);
        alarm_cutoff <= 1'b1;
        cyc(12);
        alarm_cutoff <= 1'b0;
        settle;
        chk({service, deferred}, 2'b00);
        chk({cut_led, led_r[1]}, 2'b11);
        set_cond(1, 4'h0);
        cyc(4);
        for (int c = 1; c <= 9; c++)
        begin
            set_cond(0, c[3:0]);
            cyc(2);
            on = 0;
            off = 0;
            repeat (600 * T)
            begin
                @(negedge clock_in);
                if (leds[2 * tab[c][1:0]] === 1'b1)
                    on++;
                else
                    off++;
            end
            chk(tab[c][2] ? (on > 0 && off > 0) : (off == 0), 1'b1);
            set_cond(0, 4'h0);
            settle;
            chk(hist[2:0], tab[c][5:3]);
            cyc(800 * T);
        end
        chk(hist, 6'h16);
        @(posedge clock_in);
        alarm_cutoff <= 1'b1;
        cyc(1100 * T);
        settle;
        chk(leds, 6'h3F);
        cyc(2000 * T);
        settle;
        chk(hdisp, 1'b1);
        @(posedge clock_in);
        alarm_cutoff <= 1'b0;
        cyc(10);
        settle;
        chk({hdisp, hist}, 7'h00);
        final_report;
    end
endmodule
